// file: hw/arsq_pkg.sv
// Purpose: constants and types shared by the auto reclose sequencer
// Assumes: 125 MHz system clock, timers count a 1 ms tick
// Notes:   register offsets are byte addresses on a 32-bit classic bus
package arsq_pkg;

  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned TICK_MS        = 1;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TIMER_W        = 16;
  localparam int unsigned SHOTS          = 4;

  // register byte offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_ACT_TIME    = 8'h04;
  localparam logic [7:0] REG_MAXST_TIME  = 8'h08;
  localparam logic [7:0] REG_RECLAIM     = 8'h0C;
  localparam logic [7:0] REG_CBSUP_TIME  = 8'h10;
  localparam logic [7:0] REG_DYNBLK_TIME = 8'h14;
  localparam logic [7:0] REG_MANCL_TIME  = 8'h18;
  localparam logic [7:0] REG_CLOSE_TIME  = 8'h1C;
  localparam logic [7:0] REG_DT1PH_BASE  = 8'h20;
  localparam logic [7:0] REG_DT3PH_BASE  = 8'h30;
  localparam logic [7:0] REG_STATUS      = 8'h40;

  // control register fields
  localparam int unsigned CTRL_OP_BIT    = 0;
  localparam int unsigned CTRL_SRC_BIT   = 1;
  localparam int unsigned CTRL_CYC_LSB   = 4;
  localparam int unsigned CTRL_CYC_W     = 3;

  // reset values (ms)
  localparam logic [31:0]        CTRL_RESET = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] TIME_RESET = 16'h0064;

  typedef enum logic [1:0] {
    ARSQ_SRC_TRIP_RESET,
    ARSQ_SRC_CB_OPEN
  } arsq_src_type;

  typedef enum logic {
    ARSQ_SRC_DUMMY0,
    ARSQ_SRC_DUMMY1
  } arsq_unused_type;

  typedef enum {
    ARSQ_IDLE,
    ARSQ_ACTION,
    ARSQ_START_SUP,
    ARSQ_DEAD,
    ARSQ_CB_WAIT,
    ARSQ_CLOSE,
    ARSQ_RECLAIM,
    ARSQ_DYN_BLOCK,
    ARSQ_MAN_BLOCK
  } arsq_state_type;

endpackage : arsq_pkg

// file: hw/arsq_tick.sv
// Purpose: one-cycle enable pulse every millisecond
// Assumes: synchronous active-high reset
// Notes:   divider only, no other state
`timescale 1ns/1ps
module arsq_tick #(
  parameter int unsigned DIV = arsq_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // tick
  output logic      tick_o
);
  import arsq_pkg::*;

  localparam int unsigned CW = $clog2(DIV);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_next;

  // refused at elaboration: a divider of one would never idle the tick
  if (DIV < 2) begin : g_div_check
    $error("arsq_tick: DIV must be at least 2");
  end

  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + 1'b1;
    if (cnt_reg == CW'(DIV - 1)) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o  <= tick_next;
    end
  end

endmodule : arsq_tick

// file: hw/arsq_top.sv
// Purpose: auto reclose sequencer with Wishbone settings registers
// Assumes: protection and breaker inputs come from pins, two-flop synced
// Notes:   all timers count in ms; settings take effect at next timer load
//
// How it works
// RULE1: up to four reclose shots per fault sequence, then give up.
// RULE2: each shot has its own single-phase and three-phase dead time.
// RULE3: protection start launches action timer; no trip in time blocks dynamically.
// RULE4: trip sets in-progress and launches start supervision timer.
// RULE5: trip release or breaker open, per start source, begins dead time.
// RULE6: dead time end issues close and starts reclaim timer.
// RULE7: protection pickup during reclaim advances to next enabled shot.
// RULE8: reclaim expiry without pickup resets sequence to first shot.
// RULE9: breaker ready required at close, waited for up to supervision time.
// RULE10: breaker not ready in time aborts, resets after dynamic block time.
// RULE11: outside logic may block; sequencer then stays idle and inactive.
// RULE12: manual close disables automatic cycles for a set interval.
// RULE13: close pulse lasts set time, withdrawn at once on any trip.
// RULE14: cycle enable picks none, one, two, three or four shots.
// RULE15: operation off switches sequencer off, no close command issued.
// RULE16: general device block blocks sequencer like its own block.
// RULE17: in-progress and other status exposed as outputs.
// RULE18: trip release source with overlong trip forces dynamic block.
// RULE19: once three-phase dead time used, later shots keep using it.
// RULE20: reduced dead time input ends running dead time at once.
// RULE21: timers count a 1 ms tick; synchronous reset returns to idle.
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module arsq_top #(
  parameter int unsigned TICK_DIV = arsq_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // protection and breaker
  input  wire logic        protection_start_in,
  input  wire logic        reclose_trigger_in,
  input  wire logic        three_phase_trip_in,
  input  wire logic        breaker_open_in,
  input  wire logic        breaker_ready_in,
  input  wire logic        reclose_block_in,
  input  wire logic        device_block_in,
  input  wire logic        manual_close_in,
  input  wire logic        reduced_dead_time_in,
  // status and command
  output logic             close_cmd_o,
  output logic             in_progress_out,
  output logic             blocked_o,
  output logic             dyn_blocked_o,
  output logic      [2:0]  shot_o
);
  import arsq_pkg::*;

  localparam int unsigned NIN = 9;

  // ---------------- input synchronisers ----------------
  logic [NIN-1:0] raw;
  logic [NIN-1:0] sync1_reg;
  logic [NIN-1:0] sync2_reg;
  assign raw = {reduced_dead_time_in, manual_close_in, device_block_in, reclose_block_in,
                breaker_ready_in, breaker_open_in, three_phase_trip_in,
                reclose_trigger_in, protection_start_in};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end
  logic pstart, trip, trip3, cb_open, cb_rdy, blk_own, blk_dev, man_cl, rdt;
  assign {rdt, man_cl, blk_dev, blk_own, cb_rdy, cb_open, trip3, trip, pstart} = sync2_reg;

  // ---------------- millisecond tick ----------------
  logic tick;
  arsq_tick #(.DIV(TICK_DIV)) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // ---------------- registers ----------------
  logic [31:0]        ctrl_reg, ctrl_next;
  logic [TIMER_W-1:0] tset_reg [7];
  logic [TIMER_W-1:0] tset_next[7];
  logic [TIMER_W-1:0] dt1_reg  [SHOTS];
  logic [TIMER_W-1:0] dt1_next [SHOTS];
  logic [TIMER_W-1:0] dt3_reg  [SHOTS];
  logic [TIMER_W-1:0] dt3_next [SHOTS];
  logic [31:0]        rdat_next;
  logic               ack_next;
  logic [31:0]        status_word;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  logic bus_req;
  logic bus_wr;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;

  always_comb begin
    ctrl_next = ctrl_reg;
    tset_next = tset_reg;
    dt1_next  = dt1_reg;
    dt3_next  = dt3_reg;
    rdat_next = wb_dat_o;
    ack_next  = bus_req;
    if (bus_req) begin
      rdat_next = 32'h0000_0000;
      if (wb_adr_i == REG_CTRL) rdat_next = ctrl_reg;
      if (wb_adr_i == REG_STATUS) rdat_next = status_word;
      for (int i = 0; i < 7; i++) begin
        if (wb_adr_i == REG_ACT_TIME + 8'(4 * i)) rdat_next = {16'h0000, tset_reg[i]};
      end
      for (int i = 0; i < SHOTS; i++) begin
        if (wb_adr_i == REG_DT1PH_BASE + 8'(4 * i)) rdat_next = {16'h0000, dt1_reg[i]};
        if (wb_adr_i == REG_DT3PH_BASE + 8'(4 * i)) rdat_next = {16'h0000, dt3_reg[i]};
      end
    end
    if (bus_wr) begin
      if (wb_adr_i == REG_CTRL) ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_0073;
      for (int i = 0; i < 7; i++) begin
        if (wb_adr_i == REG_ACT_TIME + 8'(4 * i))
          tset_next[i] = TIMER_W'(merge({16'h0000, tset_reg[i]}, wb_dat_i, wb_sel_i));
      end
      for (int i = 0; i < SHOTS; i++) begin
        if (wb_adr_i == REG_DT1PH_BASE + 8'(4 * i))
          dt1_next[i] = TIMER_W'(merge({16'h0000, dt1_reg[i]}, wb_dat_i, wb_sel_i)); // RULE2
        if (wb_adr_i == REG_DT3PH_BASE + 8'(4 * i))
          dt3_next[i] = TIMER_W'(merge({16'h0000, dt3_reg[i]}, wb_dat_i, wb_sel_i)); // RULE2
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      for (int i = 0; i < 7; i++) tset_reg[i] <= TIME_RESET;
      for (int i = 0; i < SHOTS; i++) begin
        dt1_reg[i] <= TIME_RESET;
        dt3_reg[i] <= TIME_RESET;
      end
    end else begin
      ctrl_reg <= ctrl_next;
      wb_dat_o <= rdat_next;
      wb_ack_o <= ack_next;
      tset_reg <= tset_next;
      dt1_reg  <= dt1_next;
      dt3_reg  <= dt3_next;
    end
  end

  // settings views
  logic               op_on;
  logic               src_cb;
  logic [2:0]         cyc_en;
  logic [TIMER_W-1:0] t_act, t_maxst, t_recl, t_cbsup, t_dyn, t_man, t_close;
  assign op_on   = ctrl_reg[CTRL_OP_BIT];
  assign src_cb  = ctrl_reg[CTRL_SRC_BIT];
  assign cyc_en  = ctrl_reg[CTRL_CYC_LSB +: CTRL_CYC_W];
  assign t_act   = tset_reg[0];
  assign t_maxst = tset_reg[1];
  assign t_recl  = tset_reg[2];
  assign t_cbsup = tset_reg[3];
  assign t_dyn   = tset_reg[4];
  assign t_man   = tset_reg[5];
  assign t_close = tset_reg[6];

  // ---------------- sequencer ----------------
  arsq_state_type     st_reg, st_next;
  logic [TIMER_W-1:0] tmr_reg, tmr_next;
  logic [2:0]         shot_reg, shot_next;      // shots already issued
  logic               ph3_reg, ph3_next;
  logic               close_next, inprog_next, blk_next, dyn_next;
  logic               any_block, expired, shots_left;

  assign any_block  = blk_own || blk_dev || !op_on;                // RULE11 RULE16 RULE15
  assign expired    = tick && (tmr_reg <= 16'h0001);               // RULE21
  // values above four read as four shots
  assign shots_left = (shot_reg < ((cyc_en > 3'h4) ? 3'h4 : cyc_en)); // RULE14 RULE1

  function automatic logic [TIMER_W-1:0] dec(input logic [TIMER_W-1:0] t, input logic tk);
    return (tk && t != '0) ? t - 1'b1 : t;
  endfunction : dec

  always_comb begin
    st_next   = st_reg;
    tmr_next  = dec(tmr_reg, tick);
    shot_next = shot_reg;
    ph3_next  = ph3_reg;
    case (st_reg)
      ARSQ_IDLE: begin
        shot_next = 3'h0;
        ph3_next  = 1'b0;
        if (pstart && shots_left) begin
          st_next  = ARSQ_ACTION;                                  // RULE3
          tmr_next = t_act;
        end
      end
      ARSQ_ACTION: begin
        if (trip) begin
          st_next  = ARSQ_START_SUP;                               // RULE4
          tmr_next = t_maxst;
        end else if (expired) begin
          st_next  = ARSQ_DYN_BLOCK;                               // RULE3
          tmr_next = t_dyn;
        end
      end
      ARSQ_START_SUP: begin
        if (trip3) ph3_next = 1'b1;                                // RULE19
        if (src_cb ? cb_open : !trip) begin
          st_next  = ARSQ_DEAD;                                    // RULE5
          tmr_next = (ph3_reg || trip3) ? dt3_reg[shot_reg[1:0]] : dt1_reg[shot_reg[1:0]]; // RULE2
        end else if (expired) begin
          st_next  = ARSQ_DYN_BLOCK;                               // RULE18
          tmr_next = t_dyn;
        end
      end
      ARSQ_DEAD: begin
        if (expired || rdt) begin                                  // RULE20
          st_next  = ARSQ_CB_WAIT;
          tmr_next = t_cbsup;
        end
      end
      ARSQ_CB_WAIT: begin
        if (cb_rdy) begin                                          // RULE9
          st_next   = ARSQ_CLOSE;                                  // RULE6
          tmr_next  = t_close;
          shot_next = shot_reg + 3'h1;
        end else if (expired) begin
          st_next  = ARSQ_DYN_BLOCK;                               // RULE10
          tmr_next = t_dyn;
        end
      end
      ARSQ_CLOSE: begin
        // reclaim counts from the close edge, so its remaining time runs here too
        if (trip || expired) st_next = ARSQ_RECLAIM;               // RULE13
        tmr_next = dec(tmr_reg, tick);
      end
      ARSQ_RECLAIM: begin
        if (pstart || trip) begin
          if (shots_left) begin
            st_next  = ARSQ_ACTION;                                // RULE7
            tmr_next = t_act;
          end else begin
            st_next  = ARSQ_DYN_BLOCK;                             // RULE1
            tmr_next = t_dyn;
          end
        end else if (expired) begin
          st_next = ARSQ_IDLE;                                     // RULE8
        end
      end
      ARSQ_DYN_BLOCK: begin
        if (expired) st_next = ARSQ_IDLE;                          // RULE10
      end
      ARSQ_MAN_BLOCK: begin
        if (expired) st_next = ARSQ_IDLE;                          // RULE12
      end
      default: st_next = ARSQ_IDLE;
    endcase
    if (man_cl) begin
      st_next  = ARSQ_MAN_BLOCK;                                   // RULE12
      tmr_next = t_man;
    end else if (any_block && st_reg != ARSQ_MAN_BLOCK) begin
      st_next = ARSQ_IDLE;                                         // RULE11
    end
  end

  // reclaim timer runs in parallel from the close edge
  logic [TIMER_W-1:0] recl_reg, recl_next;
  always_comb begin
    recl_next = dec(recl_reg, tick);
    if (st_reg == ARSQ_CB_WAIT && st_next == ARSQ_CLOSE) recl_next = t_recl; // RULE6
  end

  always_comb begin
    close_next  = (st_next == ARSQ_CLOSE) && !trip && !any_block; // RULE13 RULE15
    inprog_next = (st_next != ARSQ_IDLE) && (st_next != ARSQ_DYN_BLOCK)
                  && (st_next != ARSQ_MAN_BLOCK) && (st_next != ARSQ_ACTION); // RULE17
    blk_next    = any_block || (st_next == ARSQ_MAN_BLOCK);       // RULE17
    dyn_next    = (st_next == ARSQ_DYN_BLOCK);                    // RULE17
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg          <= ARSQ_IDLE;                                // RULE21
      tmr_reg         <= '0;
      recl_reg        <= '0;
      shot_reg        <= 3'h0;
      ph3_reg         <= 1'b0;
      close_cmd_o     <= 1'b0;
      in_progress_out <= 1'b0;
      blocked_o       <= 1'b0;
      dyn_blocked_o   <= 1'b0;
      shot_o          <= 3'h0;
    end else begin
      st_reg          <= (st_next == ARSQ_RECLAIM && st_reg == ARSQ_CLOSE) ? st_next : st_next;
      tmr_reg         <= (st_next == ARSQ_RECLAIM) ? recl_next : tmr_next;
      recl_reg        <= recl_next;
      shot_reg        <= shot_next;
      ph3_reg         <= ph3_next;
      close_cmd_o     <= close_next;
      in_progress_out <= inprog_next;
      blocked_o       <= blk_next;
      dyn_blocked_o   <= dyn_next;
      shot_o          <= shot_next;
    end
  end

  assign status_word = {16'h0000, 5'h00, shot_reg, 4'h0, dyn_blocked_o, blocked_o,
                        in_progress_out, close_cmd_o};

endmodule : arsq_top

// file: tb/arsq_top_asserts.sv
// Purpose: port level checks for the reclose sequencer
// Assumes: one clock, rst_i synchronous and active high
// Notes:   inputs pass two sync flops, so repetition counts carry slack
`timescale 1ns/1ps
module arsq_top_chk (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // field inputs
  input wire logic       reclose_trigger_in,
  input wire logic       breaker_ready_in,
  input wire logic       reclose_block_in,
  input wire logic       device_block_in,
  input wire logic       manual_close_in,
  // status
  input wire logic       close_cmd_o,
  input wire logic       in_progress_out,
  input wire logic       blocked_o,
  input wire logic       dyn_blocked_o,
  input wire logic [2:0] shot_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after a taken request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_own_block: assert property (reclose_block_in [*5] |=> blocked_o && !in_progress_out)
    else $error("own block did not hold the sequencer");
  chk_dev_block: assert property (device_block_in [*5] |=> blocked_o && !close_cmd_o)
    else $error("device block did not hold the sequencer");
  chk_trip_drop: assert property (reclose_trigger_in [*4] |=> !close_cmd_o)
    else $error("close kept during a trip");
  chk_ready_gate: assert property (!breaker_ready_in [*5] |=> !$rose(close_cmd_o))
    else $error("close issued with breaker not ready");
  chk_shot_step: assert property ($rose(close_cmd_o) |-> ##[0:1] shot_o == $past(shot_o, 2) + 3'h1)
    else $error("shot count not stepped by one at close");
  chk_shot_max: assert property (shot_o <= 3'h4)
    else $error("shot count above four");
  chk_close_run: assert property (close_cmd_o |-> in_progress_out)
    else $error("close without in progress");
  chk_dyn_quiet: assert property (dyn_blocked_o |-> !close_cmd_o && !in_progress_out)
    else $error("activity while dynamically blocked");
  chk_man_hold: assert property (manual_close_in |-> ##[2:6] (blocked_o && !close_cmd_o))
    else $error("manual close did not disable");

  cov_close: cover property ($rose(close_cmd_o));
  cov_dyn: cover property ($rose(dyn_blocked_o));
  cov_two: cover property (shot_o == 3'h2);
endmodule : arsq_top_chk

bind arsq_top arsq_top_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .reclose_trigger_in, .breaker_ready_in, .reclose_block_in, .device_block_in,
  .manual_close_in, .close_cmd_o, .in_progress_out, .blocked_o, .dyn_blocked_o, .shot_o);

// file: tb/arsq_far.sv
// Purpose: protection and breaker stand-in facing the sequencer
// Assumes: one fault per go pulse, timing in clock cycles
// Notes:   trip rises five cycles after go; long trips only when asked
`timescale 1ns/1ps
module arsq_far (
  // clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic        no_trip_i,
  input  wire logic        three_i,
  input  wire logic        ready_i,
  input  wire logic [15:0] trip_len_i,
  input  wire logic [15:0] open_dly_i,
  // toward the sequencer
  input  wire logic        close_i,
  output logic             start_o,
  output logic             trip_o,
  output logic             three_o,
  output logic             open_o,
  output logic             ready_o
);
  logic [15:0] cnt_reg = 16'hFFFF;
  logic        open_reg = 1'b0;

  always @(posedge clk_i) begin
    if (rst_i) cnt_reg <= 16'hFFFF;
    else if (go_i) cnt_reg <= 16'h0;
    else if (cnt_reg != 16'hFFFF) cnt_reg <= cnt_reg + 16'h1;
    // breaker recloses on command
    if (rst_i || go_i || close_i) open_reg <= 1'b0;
    else if (cnt_reg == 16'h5 + open_dly_i) open_reg <= 1'b1;
  end

  // pickup comes first, trip follows while picked up
  assign start_o = cnt_reg < 16'h5 + trip_len_i;
  assign trip_o  = !no_trip_i && cnt_reg >= 16'h5 && start_o;
  assign three_o = three_i && trip_o;
  assign open_o  = open_reg;
  assign ready_o = ready_i;
endmodule : arsq_far

// file: tb/tb_auto_reclose_sequencer.sv
// Purpose: self-checking bench for the reclose sequencer
// Assumes: tick divider shortened to ten cycles per ms
// Notes:   timing windows allow N-2..N ticks, N-4..N for the breaker wait, plus sync latency
`timescale 1ns/1ps
module tb_auto_reclose_sequencer;
  import arsq_pkg::*;
  localparam int DIV   = 10;
  localparam int LIMIT = 20000;
  localparam logic [15:0] TV [15] = '{16'h14, 16'h14, 16'h1E, 16'hA, 16'hA, 16'hA, 16'h5,
    16'h3, 16'h6, 16'h9, 16'hC, 16'hF, 16'h12, 16'h15, 16'h18};
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, close_cmd_o, in_progress_out, blocked_o, dyn_blocked_o;
  logic [2:0]  shot_o;
  logic        reclose_block_in = 1'b0, device_block_in = 1'b0, manual_close_in = 1'b0;
  logic        reduced_dead_time_in = 1'b0, go = 1'b0, no_trip = 1'b0, three = 1'b0;
  logic        ready = 1'b1, pstart, ptrip, pthree, popen, pready;
  logic [15:0] tlen = 16'hA, odly = 16'h0;
  int          n_mismatch = 0, compares = 0, ticks = 0, c, c0;

  always #4 clk_i = ~clk_i;

  arsq_top #(.TICK_DIV(DIV)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .protection_start_in(pstart),
    .reclose_trigger_in(ptrip), .three_phase_trip_in(pthree), .breaker_open_in(popen),
    .breaker_ready_in(pready), .reclose_block_in, .device_block_in, .manual_close_in,
    .reduced_dead_time_in, .close_cmd_o, .in_progress_out, .blocked_o, .dyn_blocked_o, .shot_o);
  arsq_far far (.clk_i, .rst_i, .go_i(go), .no_trip_i(no_trip), .three_i(three), .ready_i(ready),
    .trip_len_i(tlen), .open_dly_i(odly), .close_i(close_cmd_o), .start_o(pstart),
    .trip_o(ptrip), .three_o(pthree), .open_o(popen), .ready_o(pready));

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  // window in ms plus a fixed cycle offset
  task automatic tm(input string n, input int lo, input int hi, input int base, input int v);
    compares++;
    if (v < lo * DIV + base || v > hi * DIV + base + 10) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d to %0d seen %0d", n, lo * DIV + base,
        hi * DIV + base + 10, v);
    end
  endtask : tm

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  function automatic logic sg(input int k);
    case (k)
      0: return close_cmd_o;
      1: return dyn_blocked_o;
      2: return in_progress_out;
      default: return blocked_o;
    endcase
  endfunction : sg

  task automatic wt(input int k, input logic v);
    c = 0;
    while (sg(k) !== v && c < 3000) begin
      @(posedge clk_i);
      c++;
    end
  endtask : wt

  task automatic fault();
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : fault

  // reset wipes the settings, so every scenario after s_regs reloads them
  task automatic cfg(input logic [31:0] ctrl);
    @(posedge clk_i);
    rst_i   <= 1'b1;
    no_trip <= 1'b0;
    three   <= 1'b0;
    ready   <= 1'b1;
    tlen    <= 16'hA;
    odly    <= 16'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 15; i++) wb(1'b1, REG_ACT_TIME + 8'(4 * i), 32'(TV[i]));
    wb(1'b1, REG_CTRL, ctrl);
  endtask : cfg

  task automatic quiet(input string n, input logic b);
    int k;
    k = 0;
    fault();
    repeat (300) begin
      @(posedge clk_i);
      if (close_cmd_o !== 1'b0) k++;
    end
    chk(n, 32'h0, 32'(k));
    if (b) chk(n, 32'h1, 32'(blocked_o));
  endtask : quiet

  task automatic s_regs();
    for (int i = 0; i < 15; i++) begin
      wb(1'b0, REG_ACT_TIME + 8'(4 * i), 32'h0);
      chk("timer reset", 32'(TIME_RESET), rd);
    end
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", CTRL_RESET, rd);
    wb(1'b1, REG_STATUS, 32'hFFFFFFFF);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h4, rd);
    wb(1'b0, 8'h44, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, REG_RECLAIM, 32'hABCD1234);
    wb(1'b0, REG_RECLAIM, 32'h0);
    chk("timer width", 32'h1234, rd);
    for (int k = 0; k < 6; k++) begin
      wb(1'b1, REG_CTRL, 32'(k << 4));
      wb(1'b0, REG_CTRL, 32'h0);
      chk("cycles", 32'(k << 4), rd);
    end
  endtask : s_regs

  task automatic s_shots();
    cfg(32'h21);
    fault();
    repeat (3) @(posedge clk_i);
    chk("action run", 32'h0, 32'(in_progress_out));
    wt(0, 1'b1);
    tm("dead 1", 1, 3, 12, c);
    chk("run", 32'h1, 32'(in_progress_out));
    chk("shot", 32'h1, 32'(shot_o));
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status close", 32'h103, rd);
    wt(0, 1'b0);
    tm("close", 3, 5, 0, c);
    fault();
    wt(0, 1'b1);
    tm("dead 2", 4, 6, 15, c);
    chk("shot", 32'h2, 32'(shot_o));
    wt(0, 1'b0);
    fault();
    wt(1, 1'b1);
    chk("over", 32'h1, 32'(dyn_blocked_o));
  endtask : s_shots

  task automatic s_three();
    cfg(32'h41);
    three <= 1'b1;
    fault();
    wt(0, 1'b1);
    tm("dead 3ph", 13, 15, 15, c);
    three <= 1'b0;
    wt(0, 1'b0);
    fault();
    wt(0, 1'b1);
    tm("sticky", 16, 18, 15, c);
    wt(0, 1'b0);
    c0 = c;
    wt(2, 1'b0);
    tm("reclaim", 28, 30, 0, c0 + c);
    fault();
    wt(0, 1'b1);
    tm("restart", 1, 3, 15, c);
  endtask : s_three

  task automatic s_cb();
    cfg(32'h11);
    ready <= 1'b0;
    fault();
    wt(1, 1'b1);
    tm("cb wait", 9, 13, 15, c);
    ready <= 1'b1;
    wt(1, 1'b0);
    tm("dyn hold", 8, 10, 0, c);
    chk("idle", 32'h0, 32'(in_progress_out));
  endtask : s_cb

  task automatic s_start();
    cfg(32'h11);
    no_trip <= 1'b1;
    tlen    <= 16'h190;
    fault();
    wt(1, 1'b1);
    tm("action", 18, 20, 0, c);
    cfg(32'h11);
    tlen <= 16'h190;
    fault();
    wt(1, 1'b1);
    tm("long trip", 18, 20, 5, c);
  endtask : s_start

  task automatic s_src();
    cfg(32'h13);
    odly <= 16'h64;
    fault();
    wt(0, 1'b1);
    tm("open start", 1, 3, 105, c);
    cfg(32'h11);
    three <= 1'b1;
    reduced_dead_time_in <= 1'b1;
    fault();
    wt(0, 1'b1);
    tm("short dead", 0, 1, 15, c);
    reduced_dead_time_in <= 1'b0;
    fault();
    wt(0, 1'b0);
    chk("withdraw", 32'h1, 32'(c < 12));
  endtask : s_src

  task automatic s_block();
    cfg(32'h0);
    quiet("op off", 1'b1);
    cfg(32'h1);
    quiet("no cycles", 1'b0);
    cfg(32'h11);
    reclose_block_in <= 1'b1;
    quiet("own block", 1'b1);
    reclose_block_in <= 1'b0;
    device_block_in <= 1'b1;
    quiet("device block", 1'b1);
    device_block_in <= 1'b0;
    manual_close_in <= 1'b1;
    @(posedge clk_i);
    manual_close_in <= 1'b0;
    wt(3, 1'b1);
    wt(3, 1'b0);
    tm("manual hold", 8, 10, 0, c);
  endtask : s_block

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs();
    s_shots();
    s_three();
    s_cb();
    s_start();
    s_src();
    s_block();
    end_of_test();
  end
endmodule : tb_auto_reclose_sequencer
